// ---- hdl/dlvt_pkg.sv ----
// Constants and types shared by the video-timing register block.
package dlvt_pkg;

  // Register offsets on the byte-wide register port.
  localparam logic [7:0] ADR_LEN_B_LO = 8'h22;
  localparam logic [7:0] ADR_LEN_B_HI = 8'h23;
  localparam logic [7:0] ADR_VSZ_A_LO = 8'h24;
  localparam logic [7:0] ADR_VSZ_A_HI = 8'h25;
  localparam logic [7:0] ADR_VSZ_B_LO = 8'h26;
  localparam logic [7:0] ADR_VSZ_B_HI = 8'h27;
  localparam logic [7:0] ADR_LAG_A_LO = 8'h28;
  localparam logic [7:0] ADR_LAG_A_HI = 8'h29;
  localparam logic [7:0] ADR_LAG_B_LO = 8'h2a;
  localparam logic [7:0] ADR_LAG_B_HI = 8'h2b;
  localparam logic [7:0] ADR_MODE = 8'he0;
  localparam logic [7:0] ADR_STATUS = 8'he1;

  // Number of byte registers in the timing window and 12-bit pairs in it.
  localparam int NUM_TREGS = 10;
  localparam int NUM_PAIRS = 5;

  // Pair indices inside the committed value array.
  localparam int PAIR_LEN_B = 0;
  localparam int PAIR_VSZ_A = 1;
  localparam int PAIR_VSZ_B = 2;
  localparam int PAIR_LAG_A = 3;
  localparam int PAIR_LAG_B = 4;

  // Reset values.
  localparam logic [7:0] TREG_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [11:0] VAL12_RST = 12'h000;

  // Mode register field positions.
  localparam int MODE_IN_LSB = 0;
  localparam int MODE_CH_LSB = 2;
  localparam int MODE_SINGLE_LINK_BIT = 4;
  localparam int MODE_TP_BIT = 5;
  localparam logic [7:0] MODE_WMASK = 8'h3f;

  // Status register field positions.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DIRTY_BIT = 1;

  // Fixed latency of the sync path up to the delay line output, besides the programmed lag, in pixel clocks.
  localparam int PIPE_LAT_CYC = 10;
  // Register stages of the delay line that already count toward that latency.
  localparam int PIPE_STAGES = 2;
  localparam logic [12:0] LAG_ADJ = 13'(PIPE_LAT_CYC - PIPE_STAGES);

  // Delay line depth: must exceed the largest lag plus the adjustment.
  localparam int DLY_AW = 13;

  // Width of the configuration snapshot handed to the pixel domain.
  localparam int CFG_W = NUM_PAIRS * 12 + 6;

  typedef enum logic [1:0] {
    IN_SINGLE = 2'b00,
    IN_ODD_EVEN = 2'b01,
    IN_LEFT_RIGHT = 2'b10,
    IN_RSVD = 2'b11
  } dlvt_in_mode_t;

  localparam logic [1:0] CH_TWO_STREAM = 2'b10;

  typedef enum logic {
    XF_IDLE = 1'b0,
    XF_WAIT = 1'b1
  } dlvt_xfer_t;

endpackage

// ---- hdl/dlvt_top.sv ----
// Video-timing registers and sync delay lines of a dual DSI to LVDS bridge.
`timescale 1ns/1ps

// Overview of operation
// R1 - With a single DSI input, the channel-B line length is ignored; the code still uses it in two-stream mode with both links.
// R2 - Odd/even mode: channel-B length counts even pixels arriving on input B.
// R3 - Left/right mode: channel-B length counts right-half pixels, input B to output B.
// R4 - Two-stream mode: channel-B length counts pixels of the independent B stream.
// R5 - Channel-B line length is 12 bits: low byte 0x22, nibble at 0x23.
// R6 - Software programs channel-B length as right pixels left after right trim.
// R7 - Channel-A vertical size serves only test patterns, on A or A and B.
// R8 - Channel-B vertical size serves only B test patterns in two-stream channel mode.
// R9 - Each vertical size is 12 bits: low byte, then nibble in next register.
// R10 - Syncs from DSI reach LVDS after the channel-A lag in other modes.
// R11 - Programmed lag adds to a fixed pipeline latency of about ten clocks.
// R12 - Software keeps every sync lag at thirty-two pixel clocks or more.
// R13 - Each sync lag is 12 bits: low byte, nibble in the high register.
// R14 - Channel-B lag drives output B only in two-stream mode with both links.
// R15 - Test pattern generation uses no sync lag on either channel.
// R16 - Upper nibble of each high register stores nothing and reads zero.
// R17 - A 12-bit value is nibble over byte, used once its high byte lands.
module dlvt_top
  import dlvt_pkg::*;
(
  input wire logic clk_i, // Register clock, 40 MHz.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic pclk_i, // Pixel clock of the link side.
  input wire logic [7:0] addr_i, // Register address.
  input wire logic [7:0] wdata_i, // Register write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  output logic [7:0] rdata_o, // Read data, one cycle after the strobe.
  input wire logic hs_a_i, // HSync decoded from DSI input A.
  input wire logic vs_a_i, // VSync decoded from DSI input A.
  input wire logic hs_b_i, // HSync decoded from DSI input B.
  input wire logic vs_b_i, // VSync decoded from DSI input B.
  output logic hs_a_o, // HSync to LVDS channel A.
  output logic vs_a_o, // VSync to LVDS channel A.
  output logic hs_b_o, // HSync to LVDS channel B.
  output logic vs_b_o, // VSync to LVDS channel B.
  output logic [11:0] len_b_o, // Active pixels per line on input B.
  output logic len_b_use_o // Channel-B line length is in force.
);

  // ---------------- Register domain ----------------

  logic [7:0] treg_q [NUM_TREGS];
  logic [7:0] mode_q;
  logic [11:0] val_q [NUM_PAIRS];
  logic [7:0] rdata_q;
  logic in_win;
  logic [3:0] widx;
  logic [7:0] ridx_off;
  logic [7:0] widx_off;
  logic [NUM_PAIRS-1:0] commit;
  logic mode_wr;

  assign widx_off = addr_i - ADR_LEN_B_LO;
  assign in_win = (addr_i >= ADR_LEN_B_LO) && (addr_i <= ADR_LAG_B_HI);
  assign widx = widx_off[3:0];
  assign mode_wr = wr_i && (addr_i == ADR_MODE);

  // The low byte alone never reaches the timing logic; the pair moves together
  // when the high byte is written, so a half-updated lag is never in force.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TREGS; gi++) begin : g_treg
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          treg_q[gi] <= TREG_RST;
        end else if (wr_i && in_win && (widx == 4'(gi))) begin
          if (gi % 2 == 1) begin
            treg_q[gi] <= {4'h0, wdata_i[3:0]}; // R16
          end else begin
            treg_q[gi] <= wdata_i;
          end
        end
      end
    end
    for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
      assign commit[gi] = wr_i && in_win && (widx == 4'(2 * gi + 1));
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          val_q[gi] <= VAL12_RST;
        end else if (commit[gi]) begin
          val_q[gi] <= {wdata_i[3:0], treg_q[2 * gi]}; // R5 R9 R13 R17
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= MODE_RST;
    end else if (mode_wr) begin
      mode_q <= wdata_i & MODE_WMASK;
    end
  end

  // Configuration crossing: a snapshot register plus a toggle handshake.
  dlvt_xfer_t xf_q;
  logic dirty_q;
  logic launch;
  logic req_tgl_q;
  logic [CFG_W-1:0] snap_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_tgl_q;
  logic [CFG_W-1:0] cfg_now;

  assign cfg_now = {mode_q[5:0], val_q[4], val_q[3], val_q[2], val_q[1], val_q[0]};
  assign launch = (xf_q == XF_IDLE) && dirty_q;

  // A change that lands while a snapshot is launched stays pending: set wins.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dirty_q <= 1'b0;
    end else begin
      dirty_q <= (dirty_q && !launch) || (|commit) || mode_wr;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xf_q <= XF_IDLE;
      req_tgl_q <= 1'b0;
      snap_q <= '0;
    end else begin
      case (xf_q)
        XF_IDLE: begin
          if (dirty_q) begin
            snap_q <= cfg_now;
            req_tgl_q <= !req_tgl_q;
            xf_q <= XF_WAIT;
          end
        end
        XF_WAIT: begin
          if (ack_s2_q == req_tgl_q) begin
            xf_q <= XF_IDLE;
          end
        end
        default: begin
          xf_q <= XF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  assign ridx_off = addr_i - ADR_LEN_B_LO;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      if (in_win) begin
        rdata_q <= treg_q[ridx_off[3:0]];
      end else if (addr_i == ADR_MODE) begin
        rdata_q <= mode_q;
      end else if (addr_i == ADR_STATUS) begin
        rdata_q <= 8'h00;
        rdata_q[STAT_BUSY_BIT] <= (xf_q == XF_WAIT);
        rdata_q[STAT_DIRTY_BIT] <= dirty_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_o = rdata_q;

  // ---------------- Pixel domain ----------------

  logic [1:0] prst_q;
  logic prstn;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic [CFG_W-1:0] cfg_q;

  // Reset enters asynchronously and is released on the pixel clock.
  always_ff @(posedge pclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prst_q <= 2'b00;
    end else begin
      prst_q <= {prst_q[0], 1'b1};
    end
  end

  assign prstn = prst_q[1];

  always_ff @(posedge pclk_i or negedge prstn) begin
    if (!prstn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      cfg_q <= '0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      ack_tgl_q <= req_s2_q;
      if (req_s2_q != req_s3_q) begin
        cfg_q <= snap_q;
      end
    end
  end

  logic [11:0] len_b;
  logic [11:0] vsz_a;
  logic [11:0] vsz_b;
  logic [11:0] lag_a;
  logic [11:0] lag_b;
  logic [1:0] in_mode;
  logic [1:0] ch_mode;
  logic single_link_select_bit;
  logic tp_en;
  logic two_stream;
  logic len_b_on;

  assign len_b = cfg_q[PAIR_LEN_B*12 +: 12];
  assign vsz_a = cfg_q[PAIR_VSZ_A*12 +: 12];
  assign vsz_b = cfg_q[PAIR_VSZ_B*12 +: 12];
  assign lag_a = cfg_q[PAIR_LAG_A*12 +: 12];
  assign lag_b = cfg_q[PAIR_LAG_B*12 +: 12];
  assign in_mode = cfg_q[NUM_PAIRS*12 + MODE_IN_LSB +: 2];
  assign ch_mode = cfg_q[NUM_PAIRS*12 + MODE_CH_LSB +: 2];
  assign single_link_select_bit = cfg_q[NUM_PAIRS*12 + MODE_SINGLE_LINK_BIT];
  assign tp_en = cfg_q[NUM_PAIRS*12 + MODE_TP_BIT];
  assign two_stream = (ch_mode == CH_TWO_STREAM) && !single_link_select_bit; // R14
  // A reserved input mode leaves the length out of force outside two-stream mode, so an unused length
  // is always shown as zero and never as a stale count.
  assign len_b_on = (in_mode == IN_ODD_EVEN) || (in_mode == IN_LEFT_RIGHT) || two_stream; // R2 R3 R4

  // Channel-B line length: dropped for a single or reserved input outside two-stream mode with both links, else handed downstream
  // as even, right-half or second-stream count according to the input and channel modes.
  always_ff @(posedge pclk_i or negedge prstn) begin
    if (!prstn) begin
      len_b_o <= VAL12_RST;
      len_b_use_o <= 1'b0;
    end else if (!len_b_on) begin
      len_b_o <= VAL12_RST; // R1
      len_b_use_o <= 1'b0; // R1
    end else begin
      len_b_o <= len_b; // R2 R3 R4
      len_b_use_o <= 1'b1;
    end
  end

  // Per-channel sync delay line and test pattern vertical counter.
  logic [DLY_AW-1:0] wp_q;
  logic [1:0] dly_q [2];
  logic [1:0] tp_q [2];
  logic full_q;

  always_ff @(posedge pclk_i or negedge prstn) begin
    if (!prstn) begin
      wp_q <= '0;
    end else begin
      wp_q <= wp_q + 13'h0001;
    end
  end

  // After reset the line holds no history; until the write pointer has passed
  // the lag once, a read would return unwritten entries, so idle is sent.
  always_ff @(posedge pclk_i or negedge prstn) begin
    if (!prstn) begin
      full_q <= 1'b0;
    end else if (wp_q == '1) begin
      full_q <= 1'b1;
    end
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      logic [1:0] mem [2**DLY_AW];
      logic [1:0] in_q;
      logic [11:0] lag;
      logic [12:0] dly;
      logic [11:0] vsz;
      logic [11:0] line_q;
      logic hs_rise;

      // The delay line is one entry per pixel clock, so the lag is exact and
      // independent of sync polarity or pulse width; the price is the RAM.
      assign lag = (gi == 1 && two_stream) ? lag_b : lag_a; // R10 R14
      assign dly = {1'b0, lag} + LAG_ADJ; // R11
      assign vsz = (gi == 1 && two_stream) ? vsz_b : vsz_a; // R7 R8
      assign hs_rise = (gi == 0 ? hs_a_i : hs_b_i) && !in_q[1];

      always_ff @(posedge pclk_i or negedge prstn) begin
        if (!prstn) begin
          in_q <= 2'b00;
        end else if (gi == 0) begin
          in_q <= {hs_a_i, vs_a_i};
        end else begin
          in_q <= {hs_b_i, vs_b_i};
        end
      end

      always_ff @(posedge pclk_i) begin
        mem[wp_q] <= in_q;
      end

      always_ff @(posedge pclk_i or negedge prstn) begin
        if (!prstn) begin
          dly_q[gi] <= 2'b00;
        end else if (full_q || (wp_q >= dly)) begin
          dly_q[gi] <= mem[wp_q - dly]; // R10 R11
        end else begin
          dly_q[gi] <= 2'b00;
        end
      end

      // Test pattern frame: vsync spans the first line of every vsz lines.
      always_ff @(posedge pclk_i or negedge prstn) begin
        if (!prstn) begin
          line_q <= VAL12_RST;
          tp_q[gi] <= 2'b00;
        end else begin
          if (hs_rise) begin
            if (line_q + 12'h001 >= vsz) begin
              line_q <= VAL12_RST; // R7 R8
            end else begin
              line_q <= line_q + 12'h001;
            end
          end
          tp_q[gi] <= {in_q[1], (line_q == VAL12_RST)}; // R15
        end
      end
    end
  endgenerate

  // Output selection; test patterns bypass the lag entirely.
  logic [1:0] out_a;
  logic [1:0] out_b;

  always_comb begin
    out_a = tp_en ? tp_q[0] : dly_q[0]; // R15
    if (single_link_select_bit) begin
      out_b = 2'b00;
    end else if (two_stream) begin
      out_b = tp_en ? tp_q[1] : dly_q[1]; // R14
    end else begin
      out_b = out_a; // R10
    end
  end

  always_ff @(posedge pclk_i or negedge prstn) begin
    if (!prstn) begin
      hs_a_o <= 1'b0;
      vs_a_o <= 1'b0;
      hs_b_o <= 1'b0;
      vs_b_o <= 1'b0;
    end else begin
      hs_a_o <= out_a[1];
      vs_a_o <= out_a[0];
      hs_b_o <= out_b[1];
      vs_b_o <= out_b[0];
    end
  end

endmodule

// ---- bench/dlvt_top_properties.sv ----
// Checker for the video-timing register block.
`timescale 1ns/1ps
module dlvt_top_properties
  import dlvt_pkg::*;
(
  input wire logic clk_i, // Reg clock.
  input wire logic rstn_i, // Reset.
  input wire logic pclk_i, // Pixel clock.
  input wire logic [7:0] addr_i, // Address.
  input wire logic [7:0] wdata_i, // Write data.
  input wire logic wr_i, // Write.
  input wire logic rd_i, // Read.
  input wire logic [7:0] rdata_o, // Read data.
  input wire logic hs_a_o, // Sync A.
  input wire logic vs_a_o, // Sync A.
  input wire logic hs_b_o, // Sync B.
  input wire logic vs_b_o, // Sync B.
  input wire logic [11:0] len_b_o, // Length B.
  input wire logic len_b_use_o // Length B used.
);
  logic [7:0] reg_q [NUM_TREGS];
  logic [7:0] mode_q;
  logic [7:0] exp_q;
  logic chk_q;
  logic [11:0] len_q;
  logic [6:0] calm_q;
  logic in_win;
  logic [3:0] idx;
  logic settled;
  logic two_st;
  logic use_exp;
  assign in_win = addr_i >= ADR_LEN_B_LO && addr_i <= ADR_LAG_B_HI;
  assign idx = 4'(addr_i - ADR_LEN_B_LO);
  // Mode is trusted across domains only once it has been quiet far longer than the crossing takes.
  assign settled = calm_q == 7'h7f;
  assign two_st = mode_q[3:2] == CH_TWO_STREAM && !mode_q[MODE_SINGLE_LINK_BIT];
  assign use_exp = mode_q[1:0] == 2'b01 || mode_q[1:0] == 2'b10 || two_st;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_TREGS; i++) begin
        reg_q[i] <= 8'h00;
      end
    end else if (wr_i && in_win) begin
      reg_q[idx] <= idx[0] ? {4'h0, wdata_i[3:0]} : wdata_i;
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= 8'h00;
      len_q <= 12'h000;
    end else if (wr_i) begin
      if (addr_i == ADR_MODE) mode_q <= wdata_i & MODE_WMASK;
      if (addr_i == ADR_LEN_B_HI) len_q <= {wdata_i[3:0], reg_q[0]};
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) calm_q <= 7'h00;
    else if (wr_i && (addr_i == ADR_MODE || addr_i == ADR_LEN_B_HI)) calm_q <= 7'h00;
    else if (!settled) calm_q <= calm_q + 7'h01;
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chk_q <= 1'b0;
      exp_q <= 8'h00;
    end else begin
      chk_q <= rd_i && addr_i != ADR_STATUS;
      exp_q <= in_win ? reg_q[idx] : (addr_i == ADR_MODE ? mode_q : 8'h00);
    end
  end
  AST_REG_READ: assert property (@(posedge clk_i) disable iff (!rstn_i) chk_q |-> rdata_o == exp_q)
    else $error("read data differs from stored value");
  AST_RD_IDLE: assert property (@(posedge clk_i) disable iff (!rstn_i) !$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read");
  AST_HI_NIBBLE: assert property (@(posedge clk_i) disable iff (!rstn_i) rd_i && in_win && idx[0] |=> rdata_o[7:4] == 4'h0)
    else $error("upper nibble not zero");
  AST_LEN_B_IGN: assert property (@(posedge pclk_i) disable iff (!rstn_i) !len_b_use_o |-> len_b_o == 12'h000)
    else $error("length B shown while unused");
  AST_LEN_B_ON: assert property (@(posedge pclk_i) disable iff (!rstn_i)
    settled && mode_q[1:0] != 2'b11 |-> len_b_use_o == use_exp)
    else $error("length B use flag wrong for mode");
  AST_LEN_B_VAL: assert property (@(posedge pclk_i) disable iff (!rstn_i) settled && len_b_use_o |-> len_b_o == len_q)
    else $error("length B value wrong");
  AST_B_OFF: assert property (@(posedge pclk_i) disable iff (!rstn_i)
    settled && mode_q[MODE_SINGLE_LINK_BIT] |-> !hs_b_o && !vs_b_o)
    else $error("sync B active with one link");
  AST_B_COPY: assert property (@(posedge pclk_i) disable iff (!rstn_i)
    settled && !two_st && !mode_q[MODE_SINGLE_LINK_BIT] |-> hs_b_o == hs_a_o && vs_b_o == vs_a_o)
    else $error("sync B differs from sync A");
endmodule
bind dlvt_top dlvt_top_properties u_props (.clk_i(clk_i), .rstn_i(rstn_i), .pclk_i(pclk_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hs_a_o(hs_a_o), .vs_a_o(vs_a_o),
  .hs_b_o(hs_b_o), .vs_b_o(vs_b_o), .len_b_o(len_b_o), .len_b_use_o(len_b_use_o));

// ---- bench/dlvt_sync_src.sv ----
// Model of the DSI decoder that hands sync levels to the block.
`timescale 1ns/1ps
module dlvt_sync_src (
  output logic hs_o, // HSync level.
  output logic vs_o // VSync level.
);
  initial begin
    hs_o = 1'b0;
    vs_o = 1'b0;
  end
  // Called just after a pixel clock edge, so the level is taken at the next edge.
  task automatic level(input logic v);
    hs_o <= v;
    vs_o <= v;
  endtask
endmodule

// ---- bench/test_dlvt_top.sv ----
// Self-checking bench for the video-timing register block.
`timescale 1ns/1ps
module test_dlvt_top
  import dlvt_pkg::*;
;
  logic clk_i, rstn_i, pclk_i, wr_i, rd_i;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic hs_a_i, vs_a_i, hs_b_i, vs_b_i, hs_a_o, vs_a_o, hs_b_o, vs_b_o, len_b_use_o;
  logic [11:0] len_b_o;
  int n_mismatch;
  int tests_run;
  dlvt_sync_src src_a (.hs_o(hs_a_i), .vs_o(vs_a_i));
  dlvt_sync_src src_b (.hs_o(hs_b_i), .vs_o(vs_b_i));
  dlvt_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .pclk_i(pclk_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hs_a_i(hs_a_i), .vs_a_i(vs_a_i), .hs_b_i(hs_b_i),
    .vs_b_i(vs_b_i), .hs_a_o(hs_a_o), .vs_a_o(vs_a_o), .hs_b_o(hs_b_o), .vs_b_o(vs_b_o),
    .len_b_o(len_b_o), .len_b_use_o(len_b_use_o));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    pclk_i = 1'b0;
    #3.7;
    forever #6 pclk_i = ~pclk_i;
  end
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  // Polls the crossing status so pixel-side checks never race a pending snapshot.
  // The tail outlasts the quiet time after which the checker trusts the mode.
  task automatic settle;
    logic [7:0] v;
    int k;
    v = 8'hff;
    k = 0;
    while (v !== 8'h00 && k < 60) begin
      rd(ADR_STATUS, v);
      k++;
    end
    if (v !== 8'h00) begin
      chk("status", 12'h000, {4'h0, v});
      wrap_up();
    end
    repeat (130) @(posedge clk_i);
  endtask
  // Counts pixel edges from the sync launch until the chosen output rises.
  // A longer lag replays older line history, so the line first runs idle.
  task automatic meas(input logic b, input int exp, input logic vs_exp, input string nm);
    int n;
    n = 0;
    repeat (exp + 4) @(posedge pclk_i);
    @(posedge pclk_i);
    if (b) src_b.level(1'b1);
    else src_a.level(1'b1);
    do begin
      @(posedge pclk_i);
      #1;
      n++;
    end while (n < 400 && (b ? hs_b_o : hs_a_o) !== 1'b1);
    chk(nm, 12'(exp), 12'(n));
    chk(nm, {11'h0, vs_exp}, {11'h0, b ? vs_b_o : vs_a_o});
    if (n >= 400) begin
      wrap_up();
    end
    @(posedge pclk_i);
    if (b) src_b.level(1'b0);
    else src_a.level(1'b0);
    repeat (exp + 4) @(posedge pclk_i);
  endtask
  initial begin
    logic [7:0] v;
    rstn_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < NUM_TREGS; i++) begin
      rd(ADR_LEN_B_LO + 8'(i), v);
      chk("reset value", 12'h000, {4'h0, v});
    end
    for (int i = 0; i < NUM_TREGS; i++) begin
      wr(ADR_LEN_B_LO + 8'(i), 8'hf0 + 8'(i));
    end
    for (int i = 0; i < NUM_TREGS; i++) begin
      rd(ADR_LEN_B_LO + 8'(i), v);
      chk("readback", i[0] ? 12'(i) : 12'h0f0 + 12'(i), {4'h0, v});
    end
    wr(8'h40, 8'hff);
    rd(8'h40, v);
    chk("unmapped", 12'h000, {4'h0, v});
    wr(ADR_MODE, 8'hff);
    rd(ADR_MODE, v);
    chk("mode", 12'h03f, {4'h0, v});
    wr(ADR_MODE, 8'h00);
    wr(ADR_LAG_A_LO, 8'h20);
    wr(ADR_LAG_A_HI, 8'h00);
    wr(ADR_LAG_B_LO, 8'h28);
    wr(ADR_LAG_B_HI, 8'h00);
    wr(ADR_LEN_B_LO, 8'hc5);
    wr(ADR_LEN_B_HI, 8'h03);
    settle();
    chk("len use", 12'h000, {11'h0, len_b_use_o});
    chk("len", 12'h000, len_b_o);
    meas(1'b0, 43, 1'b1, "lag a");
    wr(ADR_LAG_A_LO, 8'h30);
    settle();
    meas(1'b0, 43, 1'b1, "lag a low only");
    wr(ADR_LAG_A_HI, 8'h01);
    settle();
    meas(1'b0, 315, 1'b1, "lag a wide");
    for (int i = 0; i < 3; i++) begin
      wr(ADR_MODE, i == 2 ? 8'h08 : 8'(i + 1));
      settle();
      chk("len use", 12'h001, {11'h0, len_b_use_o});
      chk("len", 12'h3c5, len_b_o);
    end
    meas(1'b1, 51, 1'b1, "lag b");
    wr(ADR_MODE, 8'h18);
    settle();
    chk("len use", 12'h000, {11'h0, len_b_use_o});
    meas(1'b0, 315, 1'b1, "lag a one link");
    wr(ADR_VSZ_A_LO, 8'h00);
    wr(ADR_VSZ_A_HI, 8'h00);
    wr(ADR_MODE, 8'h20);
    settle();
    meas(1'b0, 3, 1'b1, "pattern sync");
    wrap_up();
  end
endmodule
